// *** dv/vdet_ctrl_bench.sv ***
// self-checking bench for vdet_ctrl over Avalon-MM
// assumes the supply model drives both comparator inputs
`timescale 1ns/1ps
module vdet_ctrl_bench;
  import vdet_pkg::*;
  // ----
  // signals, design and partner
  // ----
  logic              sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_writedata, avs_readdata, seed;
  logic              ch1_cmp_low, ch2_cmp_low, low_voltage_irq, ch1_reset_req, ch2_reset_req;
  logic [1:0]        ch1_threshold_select, ch2_threshold_select;
  logic [12:0]       supply_mv;
  logic [7:0]        exp_q[$], thr;
  int                fails, total_checks, cycles;
  wire  [7:0]        reqs = {5'h0, low_voltage_irq, ch2_reset_req, ch1_reset_req};
  vdet_ctrl uut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ch1_cmp_low, .ch2_cmp_low,
    .ch1_threshold_select, .ch2_threshold_select, .low_voltage_irq, .ch1_reset_req,
    .ch2_reset_req);
  vdet_supply_model model (.supply_mv, .ch2_threshold_select, .ch1_cmp_low, .ch2_cmp_low);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one bus cycle; a read notes its expected byte first
  task automatic bus(logic wr, logic [13:0] a, logic [7:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    // waitrequest seen at the negedge is what the next rising edge samples;
    // no cycle limit here, only the bench timeout ends a stuck wait
    do begin
      @(negedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // completed reads are matched to the oldest note
  always @(negedge sys_clk) if (avs_read && avs_waitrequest === 1'b0)
    chk("readdata", exp_q.pop_front(), avs_readdata[7:0]);
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ----
  // scenarios
  // ----
  initial begin
    {rst_n, avs_read, avs_write} = 3'h0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    supply_mv = 13'd5000;
    seed = 32'h47F4;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, ADDR_FLAGS_LEVELS, 8'h20);
    bus(0, ADDR_MODE_ENABLE, 8'h00);
    chk("thr2", 8'h02, {6'h0, ch2_threshold_select});
    bus(1, ADDR_MODE_ENABLE, 8'hC0);
    bus(0, ADDR_MODE_ENABLE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      thr = {2'h0, i[1:0], 2'h0, seed[1:0]};
      bus(1, ADDR_FLAGS_LEVELS, thr | 8'hCC);
      bus(0, ADDR_FLAGS_LEVELS, thr);
      chk("thr2", {6'h0, i[1:0]}, {6'h0, ch2_threshold_select});
    end
    supply_mv <= 13'd1000;
    settle();
    chk("reqs", 8'h00, reqs);
    bus(0, ADDR_FLAGS_LEVELS, thr);
    bus(1, ADDR_MODE_ENABLE, 8'h05);
    settle();
    chk("reqs", 8'h04, reqs);
    bus(0, ADDR_FLAGS_LEVELS, thr | 8'hCC);
    supply_mv <= 13'd5000;
    settle();
    chk("reqs", 8'h00, reqs);
    bus(0, ADDR_FLAGS_LEVELS, thr | 8'h88);
    bus(1, ADDR_MODE_ENABLE, 8'h00);
    bus(0, ADDR_FLAGS_LEVELS, thr | 8'h88);
    bus(1, ADDR_FLAGS_LEVELS, thr);
    bus(0, ADDR_FLAGS_LEVELS, thr);
    supply_mv <= 13'd1000;
    bus(1, ADDR_MODE_ENABLE, 8'h03);
    settle();
    chk("reqs", 8'h01, reqs);
    bus(1, ADDR_MODE_ENABLE, 8'h0C);
    settle();
    chk("reqs", 8'h02, reqs);
    bus(1, 14'h0000, 8'hFF);
    bus(0, 14'h0000, 8'h00);
    close_out();
  end
endmodule // vdet_ctrl_bench
bind vdet_ctrl vdet_ctrl_properties props (.sys_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .ch1_cmp_low, .ch2_cmp_low, .ch1_threshold_select, .ch2_threshold_select,
  .low_voltage_irq, .ch1_reset_req, .ch2_reset_req);

// *** dv/vdet_ctrl_properties.sv ***
// port-level checks for the supply-voltage detect control block
// assumes a bind from the bench top and a sync active-low reset
`timescale 1ns/1ps
module vdet_ctrl_properties
  import vdet_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              ch1_cmp_low,
  input wire logic              ch2_cmp_low,
  input wire logic [1:0]        ch1_threshold_select,
  input wire logic [1:0]        ch2_threshold_select,
  input wire logic              low_voltage_irq,
  input wire logic              ch1_reset_req,
  input wire logic              ch2_reset_req
);
  // ----
  // properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire       rd_done = avs_read & ~avs_waitrequest;
  wire [1:0] wd_thr1 = avs_writedata[1:0];
  wire [1:0] wd_thr2 = avs_writedata[5:4];
  // six quiet cycles cover two sync stages plus the request flop
  sequence quiet1_s; !ch1_cmp_low [*6]; endsequence
  sequence quiet2_s; !ch2_cmp_low [*6]; endsequence
  sequence one_wait_s; avs_waitrequest ##1 !avs_waitrequest; endsequence
  a_one_wait_state: assert property ($rose(avs_read | avs_write) |-> one_wait_s)
    else $error("bus answer not after one wait state");
  a_reset_values: assert property ($rose(rst_n) |-> ch2_threshold_select == 2'h2 &&
    ch1_threshold_select == 2'h0 && !low_voltage_irq && !ch1_reset_req && !ch2_reset_req)
    else $error("outputs not at reset values");
  a_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (rd_done && avs_address != ADDR_FLAGS_LEVELS &&
    avs_address != ADDR_MODE_ENABLE |-> avs_readdata == 32'h0) else $error("unmapped read");
  a_mode_top_zero: assert property (rd_done && avs_address == ADDR_MODE_ENABLE |->
    avs_readdata[7:6] == 2'h0) else $error("mode bits 7:6 not zero");
  a_thr_written: assert property ($rose(avs_write) && avs_address == ADDR_FLAGS_LEVELS &&
    avs_byteenable[0] |=> ch1_threshold_select == $past(wd_thr1) &&
    ch2_threshold_select == $past(wd_thr2)) else $error("threshold code not taken");
  a_no_req_one: assert property (quiet1_s |-> !ch1_reset_req)
    else $error("ch1 reset request without low supply");
  a_no_req_two: assert property (quiet2_s |-> !ch2_reset_req)
    else $error("ch2 reset request without low supply");
  a_no_irq_quiet: assert property (quiet1_s and quiet2_s |-> !low_voltage_irq)
    else $error("interrupt without low supply");
endmodule // vdet_ctrl_properties

// *** dv/vdet_supply_model.sv ***
// behavioural comparators standing for the analog ladder of both channels
// assumes supply_mv comes from the bench in millivolts
`timescale 1ns/1ps
module vdet_supply_model #(
  parameter int CH1_MV = 4500
) (
  input  wire logic [12:0] supply_mv,
  input  wire logic [1:0]  ch2_threshold_select,
  output logic             ch1_cmp_low,
  output logic             ch2_cmp_low
);
  // ----
  // comparators
  // ----
  localparam int THR2_MV [4] = '{2350, 3150, 2850, 2650};
  // no hysteresis, so outputs follow the supply at once
  assign ch2_cmp_low = int'(supply_mv) < THR2_MV[ch2_threshold_select];
  assign ch1_cmp_low = int'(supply_mv) < CH1_MV; // one tap only: other ch1 codes unknown
endmodule // vdet_supply_model

// *** include/vdet_pkg.sv ***
// package for the supply-voltage detect control block
// assumes an Avalon-MM slave with 32-bit data and byte addresses
package vdet_pkg;
  // register index values as printed; byte address is four times the index
  localparam logic [11:0] IDX_FLAGS_LEVELS = 12'hFC6;
  localparam logic [11:0] IDX_MODE_ENABLE  = 12'hFC7;
  localparam int          ADDR_W           = 14;
  localparam logic [13:0] ADDR_FLAGS_LEVELS = {IDX_FLAGS_LEVELS, 2'b00};
  localparam logic [13:0] ADDR_MODE_ENABLE  = {IDX_MODE_ENABLE, 2'b00};

  // field positions of the flags/levels register
  localparam int CH2_STICKY_BIT = 7;
  localparam int CH2_LIVE_BIT   = 6;
  localparam int CH2_THR_LSB    = 4;
  localparam int CH1_STICKY_BIT = 3;
  localparam int CH1_LIVE_BIT   = 2;
  localparam int CH1_THR_LSB    = 0;

  // field positions of the mode/enable register
  localparam int CH2_MODE_BIT = 3;
  localparam int CH2_EN_BIT   = 2;
  localparam int CH1_MODE_BIT = 1;
  localparam int CH1_EN_BIT   = 0;
  localparam logic [7:0] MODE_ENABLE_WMASK = 8'h3F;

  // reset values
  localparam logic [1:0] CH2_THR_RESET = 2'h2;
  localparam logic [1:0] CH1_THR_RESET = 2'h0;

  // ch2 threshold codes
  localparam logic [1:0] THR2_2V35 = 2'h0;
  localparam logic [1:0] THR2_3V15 = 2'h1;
  localparam logic [1:0] THR2_2V85 = 2'h2;
  localparam logic [1:0] THR2_2V65 = 2'h3;

  // response mode
  typedef enum logic {RESP_IRQ = 1'b0, RESP_RESET = 1'b1} resp_mode_t;

  // per-channel control bundle
  typedef struct packed {
    logic [1:0] threshold;
    logic       response;
    logic       enable;
  } chan_ctrl_t;
endpackage

// *** rtl/vdet_ctrl.sv ***
// supply-voltage detect control: two channels, flags, requests, register slave
// assumes comparator outputs are async to sys_clk and high while supply is low
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps

// Contract
// RL1: two independent channels, each with threshold, enable, mode, sticky and live flags.
// RL2: enable one activates detection; zero blocks requests and flag updates.
// RL3: both enables read zero after reset release.
// RL4: enabling while already low raises the selected request at once.
// RL5: channel 2 mode zero raises shared interrupt, one raises channel 2 reset.
// RL6: channel 1 mode zero raises shared interrupt, one raises channel 1 reset.
// RL7: sticky flag sets on detection and holds.
// RL8: software write may only clear a sticky flag.
// RL9: detection wins over a same-cycle software clear.
// RL10: live status is read-only, one while supply below threshold.
// RL11: channel 2 threshold code drives the analog selector, reset code 10.
// RL12: first control register resets with ch2 code 10, all else zero.
// RL13: second control register resets to all zeros.
// RL14: bits 7 and 6 of second register read zero, ignore writes.
// RL15: software writes zero to bits 5 and 4 of second register.
// RL16: interrupt mode raises interrupt when supply falls to threshold.
// RL17: reset mode holds reset request while supply stays below threshold.
// RL18: sticky flag clears only by software zero write or reset.
// RL19: live status leads sticky flag by at most two clocks.
// RL20: interrupt detections share one request; resets stay per channel.
// RL21: comparator outputs pass a two-stage synchroniser first.
module vdet_ctrl
  import vdet_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              ch1_cmp_low,
  input  wire logic              ch2_cmp_low,
  output logic      [1:0]        ch1_threshold_select,
  output logic      [1:0]        ch2_threshold_select,
  output logic                   low_voltage_irq,
  output logic                   ch1_reset_req,
  output logic                   ch2_reset_req
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  chan_ctrl_t  ch1_ctrl_ff;
  chan_ctrl_t  ch2_ctrl_ff;
  logic [1:0]  mode_spare_ff;     // bits 5:4, plain storage
  logic        ch1_sticky_ff;
  logic        ch2_sticky_ff;
  logic [1:0]  sync1_ff;
  logic [1:0]  sync2_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        ch1_live;
  logic        ch2_live;
  logic        wr_lo;
  logic        sel_flags;
  logic        sel_mode;

  // live low when channel enabled and synced comparator low
  function automatic logic live_low(input logic en, input logic cmp);
    return en & cmp;
  endfunction

  // ----------------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------------
  // two flops each; the first stage feeds nothing else
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= {sync1_ff[0], ch1_cmp_low};   // [RL21]
      sync2_ff <= {sync2_ff[0], ch2_cmp_low};   // [RL21]
    end
  end

  // gated by enable so a disabled channel stays quiet
  assign ch1_live = live_low(ch1_ctrl_ff.enable, sync1_ff[1]);  // [RL2] [RL10]
  assign ch2_live = live_low(ch2_ctrl_ff.enable, sync2_ff[1]);  // [RL2] [RL10]

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // one wait cycle per access: waitrequest drops in the cycle after the request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_lo     = avs_write & ~ack_ff & avs_byteenable[0];
  assign sel_flags = (avs_address == ADDR_FLAGS_LEVELS);
  assign sel_mode  = (avs_address == ADDR_MODE_ENABLE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ch1_ctrl_ff   <= '{threshold: CH1_THR_RESET, response: RESP_IRQ, enable: 1'b0};  // [RL3]
      ch2_ctrl_ff   <= '{threshold: CH2_THR_RESET, response: RESP_IRQ, enable: 1'b0};  // [RL12]
      mode_spare_ff <= 2'h0;                                                          // [RL13]
    end else if (wr_lo && sel_flags) begin
      ch1_ctrl_ff.threshold <= avs_writedata[CH1_THR_LSB +: 2];
      ch2_ctrl_ff.threshold <= avs_writedata[CH2_THR_LSB +: 2];   // [RL11]
    end else if (wr_lo && sel_mode) begin
      ch2_ctrl_ff.response <= avs_writedata[CH2_MODE_BIT];
      ch2_ctrl_ff.enable   <= avs_writedata[CH2_EN_BIT];          // [RL2]
      ch1_ctrl_ff.response <= avs_writedata[CH1_MODE_BIT];
      ch1_ctrl_ff.enable   <= avs_writedata[CH1_EN_BIT];          // [RL2]
      // bits 5:4 stored as written; software is expected to keep them zero
      mode_spare_ff <= avs_writedata[5:4];                        // [RL15]
    end
  end

  // ----------------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------------
  // set beats clear; writing one never sets; recovery or disable leaves it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ch1_sticky_ff <= 1'b0;
      ch2_sticky_ff <= 1'b0;
    end else begin
      if (ch1_live)                                                    // [RL7] [RL9]
        ch1_sticky_ff <= 1'b1;
      else if (wr_lo && sel_flags && !avs_writedata[CH1_STICKY_BIT])   // [RL8] [RL18]
        ch1_sticky_ff <= 1'b0;
      if (ch2_live)                                                    // [RL7] [RL9]
        ch2_sticky_ff <= 1'b1;
      else if (wr_lo && sel_flags && !avs_writedata[CH2_STICKY_BIT])   // [RL8] [RL18]
        ch2_sticky_ff <= 1'b0;
    end
  end
  // live and sticky both come off the same synced bit; sticky lags one clock [RL19]

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= 32'h0000_0000;
      if (sel_flags) begin
        rdata_ff[CH2_STICKY_BIT]        <= ch2_sticky_ff;
        rdata_ff[CH2_LIVE_BIT]          <= ch2_live;
        rdata_ff[CH2_THR_LSB +: 2]      <= ch2_ctrl_ff.threshold;
        rdata_ff[CH1_STICKY_BIT]        <= ch1_sticky_ff;
        rdata_ff[CH1_LIVE_BIT]          <= ch1_live;
        rdata_ff[CH1_THR_LSB +: 2]      <= ch1_ctrl_ff.threshold;
      end else if (sel_mode) begin
        // bits 7:6 stay zero                                        [RL14]
        rdata_ff[5:4]          <= mode_spare_ff;
        rdata_ff[CH2_MODE_BIT] <= ch2_ctrl_ff.response;
        rdata_ff[CH2_EN_BIT]   <= ch2_ctrl_ff.enable;
        rdata_ff[CH1_MODE_BIT] <= ch1_ctrl_ff.response;
        rdata_ff[CH1_EN_BIT]   <= ch1_ctrl_ff.enable;
      end
    end
  end
  assign avs_readdata = rdata_ff;

  // ----------------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------------
  // level requests follow live state, so enabling while low fires at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      low_voltage_irq <= 1'b0;
      ch1_reset_req   <= 1'b0;
      ch2_reset_req   <= 1'b0;
    end else begin
      low_voltage_irq <= (ch1_live & (ch1_ctrl_ff.response == RESP_IRQ))     // [RL6] [RL16]
                       | (ch2_live & (ch2_ctrl_ff.response == RESP_IRQ));    // [RL5] [RL20]
      ch1_reset_req   <= ch1_live & (ch1_ctrl_ff.response == RESP_RESET);    // [RL6] [RL17]
      ch2_reset_req   <= ch2_live & (ch2_ctrl_ff.response == RESP_RESET);    // [RL5] [RL4]
    end
  end

  // thresholds go straight to the analog selectors
  assign ch1_threshold_select = ch1_ctrl_ff.threshold;   // [RL1]
  assign ch2_threshold_select = ch2_ctrl_ff.threshold;   // [RL11]

endmodule // vdet_ctrl
